// ===== logic/tmc_defs.svh
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

// Counter width and extreme values.
`define TMC_CNT_W       8
`define TMC_BOTTOM      8'h00
`define TMC_MAX         8'hFF

// Waveform mode encodings on the 3-bit select.
`define TMC_WGM_NORMAL  3'h0
`define TMC_WGM_PC_FF   3'h1
`define TMC_WGM_CTC     3'h2
`define TMC_WGM_FAST_FF 3'h3
`define TMC_WGM_PC_OCA  3'h5
`define TMC_WGM_FAST_OC 3'h7

// Output mode field encodings.
`define TMC_COM_OFF     2'h0
`define TMC_COM_TOGGLE  2'h1
`define TMC_COM_CLEAR   2'h2
`define TMC_COM_SET     2'h3

// Clock select value that stops the timer.
`define TMC_CS_STOP     3'h0

// Channel count and reset values.
`define TMC_NCH         2
`define TMC_OC_RESET    1'b0
`define TMC_CNT_RESET   8'h00

`endif

// ===== logic/tmc_pkg.sv
package tmc_pkg;
	// Per-channel control carried together.
	typedef struct packed {
		logic [1:0] compare_output_mode;
		logic       force_compare_strobe;
		logic       output_pin_direction;
		logic       port_data;
	} tmc_chan_ctl_t;

	// Per-channel pin result.
	typedef struct packed {
		logic pin_out;
		logic pin_oe;
	} tmc_pin_t;

	// Interrupt flag group.
	typedef struct packed {
		logic compare_flag_b;
		logic compare_flag_a;
		logic overflow_flag;
	} tmc_flags_t;
endpackage

// ===== logic/tmc_tick_gen.sv
`timescale 1ns/1ns
`include "tmc_defs.svh"

// Turns the clock source select into a one-cycle timer tick.
// Internal divide ratios stand in for the prescaler taps; select 0 stops ticks.
module tmc_tick_gen
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [2:0] clock_source_select,
	input  wire logic       ext_tick,
	output logic            timer_tick
);
	logic [9:0] div_q;
	logic [9:0] div_d;
	logic       tick_d;

	// Free-running divider and tap selection.
	always_comb
	begin
		div_d = div_q + 10'h001;
		case (clock_source_select)
			`TMC_CS_STOP: tick_d = 1'b0;
			3'h1: tick_d = 1'b1;
			3'h2: tick_d = &div_q[2:0];
			3'h3: tick_d = &div_q[4:0];
			3'h4: tick_d = &div_q[5:0];
			3'h5: tick_d = &div_q[6:0];
			3'h6: tick_d = &div_q[7:0];
			default: tick_d = ext_tick | (&div_q);
		endcase
	end

	// Registers only.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_q      <= 10'h000;
			timer_tick <= 1'b0;
		end
		else
		begin
			div_q      <= div_d;
			timer_tick <= tick_d;
		end
	end
endmodule // tmc_tick_gen

// ===== logic/tmc_core.sv
`timescale 1ns/1ns
`include "tmc_defs.svh"

module tmc_core
	import tmc_pkg::*;
#(
	parameter int CNT_W = `TMC_CNT_W
)
(
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic [1:0]              waveform_mode_bits_a,
	input  wire logic                    waveform_mode_bit2,
	input  wire logic [2:0]              clock_source_select,
	input  wire logic                    ext_tick,
	input  wire logic                    count_wr,
	input  wire logic [CNT_W-1:0]        count_wdata,
	input  wire logic                    cmp_a_wr,
	input  wire logic                    cmp_b_wr,
	input  wire logic [CNT_W-1:0]        cmp_wdata,
	input  wire tmc_pkg::tmc_chan_ctl_t  chan_a_ctl,
	input  wire tmc_pkg::tmc_chan_ctl_t  chan_b_ctl,
	input  wire tmc_pkg::tmc_flags_t     timer_interrupt_mask,
	input  wire logic                    flags_wr,
	input  wire tmc_pkg::tmc_flags_t     flags_wdata,
	input  wire tmc_pkg::tmc_flags_t     irq_serviced,
	output logic [CNT_W-1:0]             count_value,
	output logic [CNT_W-1:0]             compare_value_a_rd,
	output logic [CNT_W-1:0]             compare_value_b_rd,
	output tmc_pkg::tmc_flags_t          timer_interrupt_flags,
	output tmc_pkg::tmc_flags_t          irq_request,
	output tmc_pkg::tmc_pin_t            pin_a,
	output tmc_pkg::tmc_pin_t            pin_b,
	output logic                         top_ind,
	output logic                         bottom_ind
);
	import tmc_pkg::*;

	logic                      timer_tick;
	logic [2:0]                wgm;
	logic                      pwm_mode;
	logic                      phase_mode;
	logic [CNT_W-1:0]          top_val;
	logic [CNT_W-1:0]          cnt_q;
	logic [CNT_W-1:0]          cnt_d;
	logic                      down_q;
	logic                      down_d;
	logic                      block_q;
	logic                      block_d;
	logic [CNT_W-1:0]          ocr_q   [`TMC_NCH];
	logic [CNT_W-1:0]          ocr_d   [`TMC_NCH];
	logic [CNT_W-1:0]          buf_q   [`TMC_NCH];
	logic [CNT_W-1:0]          buf_d   [`TMC_NCH];
	logic [`TMC_NCH-1:0]       oc_q;
	logic [`TMC_NCH-1:0]       oc_d;
	logic [`TMC_NCH-1:0]       match;
	logic [`TMC_NCH-1:0]       match_pend_q;
	logic [`TMC_NCH-1:0]       match_pend_d;
	logic [`TMC_NCH-1:0]       cmp_wr;
	logic [1:0]                com     [`TMC_NCH];
	logic [`TMC_NCH-1:0]       foc;
	logic [`TMC_NCH-1:0]       ddr;
	logic [`TMC_NCH-1:0]       port;
	tmc_flags_t                flg_q;
	tmc_flags_t                flg_d;
	tmc_flags_t                set_ev;
	tmc_pin_t                  pin_d   [`TMC_NCH];
	logic                      is_top;
	logic                      is_bot;
	logic [CNT_W-1:0]          cmp_a_rd_d;
	logic [CNT_W-1:0]          cmp_b_rd_d;
	tmc_flags_t                irq_d;
	logic                      top_d;
	logic                      bot_d;

	// Tick source; its tick is registered, so a select change acts one clock later.
	tmc_tick_gen u_tick
	(
		.clock               (clock),
		.rst_n               (rst_n),
		.clock_source_select (clock_source_select),
		.ext_tick            (ext_tick),
		.timer_tick          (timer_tick)
	);

	// Mode decode; control A holds the low two bits, control B the third.
	// Reserved modes 4 and 6 count up and clear at compare A, like clear-on-match.
	assign wgm        = {waveform_mode_bit2, waveform_mode_bits_a};
	assign pwm_mode   = wgm[0];
	assign phase_mode = wgm[0] & ~wgm[1];
	assign top_val    = (wgm == `TMC_WGM_CTC || wgm[2]) ? ocr_q[0] : `TMC_MAX;
	assign is_top     = (cnt_q == top_val);
	assign is_bot     = (cnt_q == `TMC_BOTTOM);
	assign cmp_wr     = {cmp_b_wr, cmp_a_wr};
	assign com[0]     = chan_a_ctl.compare_output_mode;
	assign com[1]     = chan_b_ctl.compare_output_mode;
	assign foc        = {chan_b_ctl.force_compare_strobe, chan_a_ctl.force_compare_strobe};
	assign ddr        = {chan_b_ctl.output_pin_direction, chan_a_ctl.output_pin_direction};
	assign port       = {chan_b_ctl.port_data, chan_a_ctl.port_data};

	// Counter next value; a CPU write always wins over counting.
	// The block flag survives a stopped timer until the next tick, so a write while
	// stopped still hides the first match once counting resumes.
	// The direction bit is kept across a count write, so the slope carries on.
	// A user who writes zero while counting down still turns up at bottom on the next tick.
	always_comb
	begin
		cnt_d   = cnt_q;
		down_d  = down_q;
		block_d = block_q;
		if (timer_tick)
		begin
			block_d = 1'b0;
			if (wgm == `TMC_WGM_NORMAL)
				cnt_d = cnt_q + 1'b1;
			else if (phase_mode)
			begin
				if (is_top)
					down_d = 1'b1;
				else if (is_bot)
					down_d = 1'b0;
				cnt_d = (is_top || (down_q && !is_bot)) ? cnt_q - 1'b1 : cnt_q + 1'b1;
			end
			else
				cnt_d = is_top ? `TMC_BOTTOM : cnt_q + 1'b1;
		end
		if (count_wr)
		begin
			cnt_d   = count_wdata;
			block_d = 1'b1;
		end
	end

	// Comparator and per-channel compare, buffer and output logic.
	// Compare values reset to zero; with the count also zero, the first tick after
	// reset matches both channels unless software moves one of them first.
	genvar ch;
	generate
		for (ch = 0; ch < `TMC_NCH; ch++)
		begin : g_ch
			assign match[ch] = (cnt_q == ocr_q[ch]);

			always_comb
			begin
				ocr_d[ch] = ocr_q[ch];
				buf_d[ch] = buf_q[ch];
				oc_d[ch]  = oc_q[ch];
				match_pend_d[ch] = match_pend_q[ch];
				if (timer_tick)
					match_pend_d[ch] = match[ch] & ~block_q;
				if (cmp_wr[ch])
				begin
					buf_d[ch] = cmp_wdata;
					if (!pwm_mode)
						ocr_d[ch] = cmp_wdata;
				end
				// Outside PWM the buffer shadows the compare value, so a later switch
				// into PWM starts from the live value rather than a stale one.
				if (pwm_mode && timer_tick && (phase_mode ? is_top : is_bot))
					ocr_d[ch] = buf_q[ch];
				else if (!pwm_mode && !cmp_wr[ch])
					buf_d[ch] = ocr_q[ch];
				// Output action; mode bits are read live so a change acts at once.
				if (timer_tick && match[ch] && !block_q && com[ch] != `TMC_COM_OFF)
				begin
					if (!pwm_mode)
						case (com[ch])
							`TMC_COM_TOGGLE: oc_d[ch] = ~oc_q[ch];
							`TMC_COM_CLEAR:  oc_d[ch] = 1'b0;
							default:         oc_d[ch] = 1'b1;
						endcase
					else if (com[ch][1])
						oc_d[ch] = phase_mode ? (down_q ^ com[ch][0])
						                      : com[ch][0];
					else if (!phase_mode && ch == 0 && wgm[2])
						oc_d[ch] = ~oc_q[ch];
				end
				else if (pwm_mode && !phase_mode && timer_tick && is_top && com[ch][1])
					oc_d[ch] = ~com[ch][0];
				// Outside PWM modes, force acts in every cycle the strobe is high, so software pulses it once.
				if (!pwm_mode && foc[ch] && com[ch] != `TMC_COM_OFF)
					case (com[ch])
						`TMC_COM_TOGGLE: oc_d[ch] = ~oc_q[ch];
						`TMC_COM_CLEAR:  oc_d[ch] = 1'b0;
						default:         oc_d[ch] = 1'b1;
					endcase
				// Pin override when either mode bit is set; direction gates drive.
				pin_d[ch].pin_out = (com[ch] != `TMC_COM_OFF) ? oc_d[ch] : port[ch];
				pin_d[ch].pin_oe  = ddr[ch];
			end

			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
				begin
					ocr_q[ch]        <= `TMC_CNT_RESET;
					buf_q[ch]        <= `TMC_CNT_RESET;
					oc_q[ch]         <= `TMC_OC_RESET;
					match_pend_q[ch] <= 1'b0;
				end
				else
				begin
					ocr_q[ch]        <= ocr_d[ch];
					buf_q[ch]        <= buf_d[ch];
					oc_q[ch]         <= oc_d[ch];
					match_pend_q[ch] <= match_pend_d[ch];
				end
			end
		end
	endgenerate

	// Flag events: compare flags one tick after the match, overflow as count hits zero outside modes 4 and 6.
	// The compare flag lags through the pending bit; the overflow flag follows the
	// new count, so it lands in the same edge as the zero it reports.
	always_comb
	begin
		set_ev.overflow_flag  = timer_tick && !count_wr && cnt_d == `TMC_BOTTOM
		                        && (wgm == `TMC_WGM_NORMAL || wgm == `TMC_WGM_CTC
		                            || (!phase_mode && pwm_mode) || phase_mode);
		set_ev.compare_flag_a = timer_tick && match_pend_q[0];
		set_ev.compare_flag_b = timer_tick && match_pend_q[1];
		// Clears come from service or a one written; a set in the same cycle wins.
		flg_d = flg_q & ~irq_serviced;
		if (flags_wr)
			flg_d = flg_d & ~flags_wdata;
		flg_d = flg_d | set_ev;
	end

	// Next values of the registered outputs. Every port comes from a flip-flop so
	// that pins and status never glitch while the counter logic settles.
	always_comb
	begin
		cmp_a_rd_d = pwm_mode ? buf_d[0] : ocr_d[0];
		cmp_b_rd_d = pwm_mode ? buf_d[1] : ocr_d[1];
		irq_d      = flg_d & timer_interrupt_mask;
		top_d      = (cnt_d == `TMC_MAX);
		bot_d      = (cnt_d == `TMC_BOTTOM);
	end

	// Counter, flag and output registers.
	// Reset loads constants only, so release is clean whatever the inputs do.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q                 <= `TMC_CNT_RESET;
			down_q                <= 1'b0;
			block_q               <= 1'b0;
			flg_q                 <= '0;
			count_value           <= `TMC_CNT_RESET;
			compare_value_a_rd    <= `TMC_CNT_RESET;
			compare_value_b_rd    <= `TMC_CNT_RESET;
			timer_interrupt_flags <= '0;
			irq_request           <= '0;
			pin_a                 <= '0;
			pin_b                 <= '0;
			top_ind               <= 1'b0;
			bottom_ind            <= 1'b0;
		end
		else
		begin
			cnt_q                 <= cnt_d;
			down_q                <= down_d;
			block_q               <= block_d;
			flg_q                 <= flg_d;
			count_value           <= cnt_d;
			compare_value_a_rd    <= cmp_a_rd_d;
			compare_value_b_rd    <= cmp_b_rd_d;
			timer_interrupt_flags <= flg_d;
			irq_request           <= irq_d;
			pin_a                 <= pin_d[0];
			pin_b                 <= pin_d[1];
			top_ind               <= top_d;
			bottom_ind            <= bot_d;
		end
	end
endmodule // tmc_core

// ===== verification/tmc_core_assertions.sv
`timescale 1ns/1ns

// Watches the core's ports; every check runs on the one clock and sleeps in reset.
module tmc_core_chk
	import tmc_pkg::*;
#(
	parameter int CNT_W = 8
)
(
	input wire logic                   clock,
	input wire logic                   rst_n,
	input wire logic [1:0]             waveform_mode_bits_a,
	input wire logic                   waveform_mode_bit2,
	input wire logic [2:0]             clock_source_select,
	input wire logic                   count_wr,
	input wire logic [CNT_W-1:0]       count_wdata,
	input wire tmc_pkg::tmc_chan_ctl_t chan_a_ctl,
	input wire tmc_pkg::tmc_flags_t    timer_interrupt_mask,
	input wire logic                   flags_wr,
	input wire tmc_pkg::tmc_flags_t    flags_wdata,
	input wire tmc_pkg::tmc_flags_t    irq_serviced,
	input wire logic [CNT_W-1:0]       count_value,
	input wire tmc_pkg::tmc_flags_t    timer_interrupt_flags,
	input wire tmc_pkg::tmc_flags_t    irq_request,
	input wire tmc_pkg::tmc_pin_t      pin_a,
	input wire logic                   top_ind
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Stop must hold two cycles, since the tick generator registers its tick.
	wire logic stop_w = clock_source_select == 3'h0;
	wire logic nrm_w  = {waveform_mode_bit2, waveform_mode_bits_a} == 3'h0;

	a_write_wins: assert property (count_wr |=> count_value == $past(count_wdata))
		else $error("Count write was not stored.");
	a_stop_holds: assert property (stop_w && $past(stop_w) && !count_wr |=> $stable(count_value))
		else $error("Count moved while stopped.");
	a_normal_up: assert property (nrm_w && clock_source_select == 3'h1 && $past(rst_n)
		&& $past(clock_source_select) == 3'h1 && !count_wr
		|=> count_value == $past(count_value) + 8'h01)
		else $error("Normal mode did not count up by one.");
	a_ovf_set: assert property (nrm_w && count_value == 8'h00 && $past(count_value) == 8'hFF
		&& !$past(count_wr) && $past(rst_n) |-> timer_interrupt_flags.overflow_flag)
		else $error("Overflow flag missed the wrap.");
	a_ovf_sticky: assert property (timer_interrupt_flags.overflow_flag && !flags_wr
		&& !irq_serviced.overflow_flag |=> timer_interrupt_flags.overflow_flag)
		else $error("Overflow flag cleared by itself.");
	a_zero_keeps: assert property (timer_interrupt_flags.compare_flag_a && flags_wr
		&& !flags_wdata.compare_flag_a && !irq_serviced.compare_flag_a
		|=> timer_interrupt_flags.compare_flag_a)
		else $error("Zero write cleared a flag.");
	a_one_clears: assert property (stop_w && $past(stop_w) && flags_wr
		&& flags_wdata.compare_flag_b |=> !timer_interrupt_flags.compare_flag_b)
		else $error("Writing one left the flag set.");
	a_irq_gate: assert property ($stable(timer_interrupt_mask)
		|-> irq_request == (timer_interrupt_flags & timer_interrupt_mask))
		else $error("Request does not match flags and mask.");
	a_pin_dir: assert property ($stable(chan_a_ctl.output_pin_direction)
		|-> pin_a.pin_oe == chan_a_ctl.output_pin_direction)
		else $error("Pin enable does not follow direction.");
	a_port_pass: assert property (chan_a_ctl.compare_output_mode == 2'h0 && $stable(chan_a_ctl)
		&& chan_a_ctl.output_pin_direction |-> pin_a.pin_out == chan_a_ctl.port_data)
		else $error("Port data not passed to the pin.");
	a_top_seen: assert property (count_value == 8'hFF && $stable(count_value) |-> top_ind)
		else $error("Top indication missing at maximum.");

	// Main scenarios reached.
	cover property (timer_interrupt_flags.overflow_flag);
	cover property (chan_a_ctl.force_compare_strobe);
	cover property (count_wr && clock_source_select == 3'h1);
endmodule // tmc_core_chk

bind tmc_core tmc_core_chk #(.CNT_W(CNT_W)) i_tmc_core_chk (.clock, .rst_n,
	.waveform_mode_bits_a, .waveform_mode_bit2, .clock_source_select, .count_wr,
	.count_wdata, .chan_a_ctl, .timer_interrupt_mask, .flags_wr, .flags_wdata,
	.irq_serviced, .count_value, .timer_interrupt_flags, .irq_request, .pin_a, .top_ind);

// ===== verification/tb_tmc_core.sv
`timescale 1ns/1ns

module tb_tmc_core;
	import tmc_pkg::*;
	logic          clock = 1'h0;
	logic          rst_n;
	logic [2:0]    sel;
	logic [2:0]    wgm;
	logic          count_wr;
	logic [7:0]    count_wdata;
	logic          cmp_a_wr;
	logic          cmp_b_wr;
	logic [7:0]    cmp_wdata;
	tmc_chan_ctl_t ca;
	tmc_chan_ctl_t cb;
	tmc_flags_t    mask;
	logic          flags_wr;
	tmc_flags_t    fwd;
	tmc_flags_t    srv;
	logic [7:0]    count_value;
	logic [7:0]    cmp_a_rd;
	logic [7:0]    cmp_b_rd;
	tmc_flags_t    flg;
	tmc_flags_t    irq;
	tmc_pin_t      pa;
	tmc_pin_t      pb;
	logic          top_ind;
	logic          bottom_ind;
	logic [7:0]    c0;
	logic [1:0]    coms [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
	logic          exps [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
	int            n_fail = 0;
	int            cmp_count = 0;

	tmc_core #(.CNT_W(8)) i_tmc_core (.clock, .rst_n, .waveform_mode_bits_a(wgm[1:0]),
		.waveform_mode_bit2(wgm[2]), .clock_source_select(sel), .ext_tick(1'h0), .count_wr,
		.count_wdata, .cmp_a_wr, .cmp_b_wr, .cmp_wdata, .chan_a_ctl(ca), .chan_b_ctl(cb),
		.timer_interrupt_mask(mask), .flags_wr, .flags_wdata(fwd), .irq_serviced(srv),
		.count_value, .compare_value_a_rd(cmp_a_rd), .compare_value_b_rd(cmp_b_rd),
		.timer_interrupt_flags(flg), .irq_request(irq), .pin_a(pa), .pin_b(pb), .top_ind,
		.bottom_ind);

	// Free-running clock, 8 ns period.
	initial
	begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end

	// Every comparison is counted; case inequality keeps unknowns from matching.
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	// One-cycle write strobe: 0 count, 1 compare A, 2 compare B.
	task wr(input int k, input logic [7:0] v);
		count_wdata = v;
		cmp_wdata = v;
		count_wr = (k == 0);
		cmp_a_wr = (k == 1);
		cmp_b_wr = (k == 2);
		cyc(1);
		{count_wr, cmp_a_wr, cmp_b_wr} = 3'h0;
	endtask

	// Flag write plus service pulse, both one cycle wide.
	task fclr(input tmc_flags_t w, input tmc_flags_t s);
		flags_wr = 1'h1;
		fwd = w;
		srv = s;
		cyc(1);
		flags_wr = 1'h0;
		srv = 3'h0;
		cyc(1);
	endtask

	task frc(input logic [1:0] com);
		ca.compare_output_mode = com;
		ca.force_compare_strobe = 1'h1;
		cyc(1);
		ca.force_compare_strobe = 1'h0;
		cyc(2);
	endtask

	// Runs on every clock until the count shows v; the bound stops a dead counter hanging.
	task run_to(input logic [7:0] v);
		sel = 3'h1;
		for (int i = 0; i < 20 && count_value !== v; i++)
			cyc(1);
		sel = 3'h0;
		chk("count", count_value, v);
		cyc(2);
	endtask

	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// The sequence needs about 200 cycles; 1000 is ample.
	initial
	begin
		#8000;
		n_fail++;
		end_sim;
	end

	// Main sequence.
	initial
	begin
		rst_n = 1'h0;
		sel = 3'h0;
		wgm = 3'h0;
		{count_wr, cmp_a_wr, cmp_b_wr, flags_wr} = 4'h0;
		{count_wdata, cmp_wdata} = 16'h0000;
		ca = 5'h00;
		cb = 5'h00;
		mask = 3'h4;
		fwd = 3'h0;
		srv = 3'h0;
		cyc(5);
		rst_n = 1'h1;
		cyc(2);
		chk("count", count_value, 8'h00);
		chk("bottom", bottom_ind, 8'h01);
		chk("flags", flg, 8'h00);
		$display("reset test ended.");
		wr(0, 8'h55);
		cyc(3);
		chk("count", count_value, 8'h55);
		wr(0, 8'hFF);
		cyc(2);
		chk("top", top_ind, 8'h01);
		$display("stopped test ended.");
		wr(0, 8'hFD);
		run_to(8'h00);
		chk("ovf", flg.overflow_flag, 8'h01);
		fclr(3'h0, 3'h0);
		chk("ovf", flg.overflow_flag, 8'h01);
		fclr(3'h0, 3'h1);
		chk("ovf", flg.overflow_flag, 8'h00);
		$display("overflow test ended.");
		wr(2, 8'h10);
		chk("cmp_b", cmp_b_rd, 8'h10);
		wr(1, 8'h10);
		chk("cmp_a", cmp_a_rd, 8'h10);
		cb.compare_output_mode = 2'h1;
		cb.output_pin_direction = 1'h1;
		wr(0, 8'h0E);
		run_to(8'h13);
		chk("flags", flg, 8'h06);
		chk("irq", irq, 8'h04);
		chk("pin_b", pb.pin_out, 8'h01);
		chk("pin_b_oe", pb.pin_oe, 8'h01);
		fclr(3'h1, 3'h0);
		chk("flags", flg, 8'h06);
		fclr(3'h7, 3'h0);
		chk("flags", flg, 8'h00);
		$display("match test ended.");
		wr(1, 8'h40);
		sel = 3'h1;
		wr(0, 8'h40);
		run_to(8'h44);
		chk("flag_a", flg.compare_flag_a, 8'h00);
		$display("blocking test ended.");
		c0 = count_value;
		chk("pin_oe", pa.pin_oe, 8'h00);
		frc(2'h2);
		ca.output_pin_direction = 1'h1;
		foreach (coms[i])
		begin
			frc(coms[i]);
			chk("pin_out", pa.pin_out, exps[i]);
		end
		chk("pin_oe", pa.pin_oe, 8'h01);
		ca.port_data = 1'h1;
		frc(2'h0);
		chk("pin_out", pa.pin_out, 8'h01);
		ca.compare_output_mode = 2'h1;
		cyc(2);
		chk("pin_out", pa.pin_out, 8'h00);
		chk("flags", flg, 8'h00);
		chk("count", count_value, c0);
		frc(2'h3);
		wgm = 3'h2;
		cyc(2);
		wgm = 3'h0;
		cyc(2);
		chk("pin_out", pa.pin_out, 8'h01);
		$display("output test ended.");
		wgm = 3'h3;
		wr(1, 8'h20);
		chk("cmp_a", cmp_a_rd, 8'h20);
		wr(0, 8'h1E);
		run_to(8'h22);
		chk("flag_a", flg.compare_flag_a, 8'h00);
		wr(0, 8'hFE);
		run_to(8'h01);
		chk("pin_out", pa.pin_out, 8'h00);
		wgm = 3'h0;
		cyc(2);
		chk("cmp_a", cmp_a_rd, 8'h20);
		$display("buffer test ended.");
		wr(0, 8'h30);
		sel = 3'h2;
		cyc(64);
		sel = 3'h0;
		cyc(2);
		chk("count", count_value, 8'h38);
		$display("prescale test ended.");
		end_sim;
	end
endmodule // tb_tmc_core
